// >>> testbench.sv
/*
  Self-checking bench for the modem handshake block over APB.
  Assumes a modem model on the pins and zero-wait APB answers.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import umh_pkg::*;
  logic clock, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic send_clearance_in_n, set_ready_in_n, carrier_detect_in_n, ring_detect_in_n;
  logic terminal_ready_out_n, send_request_out_n, modem_irq;
  logic [3:0] drive;
  logic [32:0] exp_q[$];
  int err_total, tests_run, cycles;

  umh_modem_handshake u_umh_modem_handshake (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .send_clearance_in_n(send_clearance_in_n), .set_ready_in_n(set_ready_in_n),
    .carrier_detect_in_n(carrier_detect_in_n), .ring_detect_in_n(ring_detect_in_n),
    .terminal_ready_out_n(terminal_ready_out_n), .send_request_out_n(send_request_out_n),
    .modem_irq(modem_irq));

  umh_modem_model u_umh_modem_model (
    .clock(clock), .reset(reset), .assert_req(drive),
    .send_clearance_in_n(send_clearance_in_n), .set_ready_in_n(set_ready_in_n),
    .ring_detect_in_n(ring_detect_in_n), .carrier_detect_in_n(carrier_detect_in_n));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    tests_run++;
    if (seen !== expv) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // Called right after a rising edge; one idle edge after release avoids double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Sample pins and interrupt away from the edge
  task automatic pins(input logic [1:0] e);
    @(negedge clock);
    check({31'h0, terminal_ready_out_n, send_request_out_n}, {31'h0, e});
    @(posedge clock);
  endtask

  task automatic irq_is(input logic e);
    @(negedge clock);
    check({32'h0, modem_irq}, {32'h0, e});
    @(posedge clock);
  endtask

  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Whole run is a few hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h85e6_c3fa));
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; drive = 4'h0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    pins(2'b11);
    irq_is(1'b0);
    rd(ADDR_MODEM_CONTROL, 32'h0000_0000, 1'b0);
    rd(ADDR_MODEM_STATUS, 32'h0000_0000, 1'b0);
    for (int v = 0; v < 4; v++) begin
      rnd = ($urandom & 32'hFFFF_FFEC) | v;
      apb(1'b1, ADDR_MODEM_CONTROL, rnd);
      pins({~rnd[0], ~rnd[1]});
      rd(ADDR_MODEM_CONTROL, rnd & 32'h0000_0013, 1'b0);
    end
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h0000_0013);
    pins(2'b11);
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      drive[i] <= 1'b1;
      repeat (8) @(posedge clock);
      irq_is(1'b1);
      rd(ADDR_MODEM_STATUS, 32'h0000_0010 << i, 1'b0);
      irq_is(1'b0);
      drive[i] <= 1'b0;
      repeat (8) @(posedge clock);
      irq_is(1'b1);
      rd(ADDR_MODEM_STATUS, 32'h0000_0001 << i, 1'b0);
      rd(ADDR_MODEM_STATUS, 32'h0000_0000, 1'b0);
    end
    // Masked event still latches status; clear register withdraws it
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0000);
    drive <= 4'hF;
    repeat (8) @(posedge clock);
    irq_is(1'b0);
    rd(ADDR_IRQ_STATUS, 32'h0000_0008, 1'b0);
    apb(1'b1, ADDR_IRQ_CLEAR, 32'h0000_0008);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0008);
    irq_is(1'b0);
    rd(ADDR_MODEM_STATUS, 32'h0000_00F0, 1'b0);
    rd(8'h20, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(ADDR_MODEM_CONTROL, 32'h0000_0000, 1'b0);
    // Reset in mid-run must idle pins that a control write had driven active
    apb(1'b1, ADDR_MODEM_CONTROL, 32'h0000_0003);
    pins(2'b00);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    pins(2'b11);
    irq_is(1'b0);
    reset <= 1'b0;
    @(posedge clock);
    pins(2'b11);
    rd(ADDR_MODEM_CONTROL, 32'h0000_0000, 1'b0);
    repeat (8) @(posedge clock);
    irq_is(1'b0);
    rd(ADDR_MODEM_STATUS, 32'h0000_00F0, 1'b0);
    repeat (2) @(posedge clock);
    final_report();
  end
endmodule // testbench

`default_nettype wire

// >>> umh_irq_sticky.sv
/*
  Sticky interrupt status with write-one-to-clear and an enable mask.
  Assumes set and clear arrive as single-cycle vectors on clock.
*/
`timescale 1ns/1ps
`default_nettype none

module umh_irq_sticky #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Events and software control
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clear,
  input wire logic [WIDTH-1:0] enable,
  // State and request
  output logic [WIDTH-1:0] status,
  output logic irq
);
  import umh_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // An event in the clearing cycle survives
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          status[i] <= 1'b0;
        end else begin
          status[i] <= (status[i] && !clear[i]) || set[i];
        end
      end
    end
  endgenerate

  assign irq = |(status & enable);

  chk_set_wins: assert property (@(posedge clock) disable iff (reset)
    set[IRQ_MODEM_BIT] |=> status[IRQ_MODEM_BIT])
    else $error("Interrupt event lost against a clear");

endmodule // umh_irq_sticky

`default_nettype wire

// >>> umh_modem_handshake.sv
/*
  Modem handshake logic of one serial port: control outputs, status
  register with change flags, modem interrupt, all behind an APB slave.
  Assumes one clock at 10 MHz, asynchronous pins, and a modem that drives
  its status lines low when asserted.
*/
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module umh_modem_handshake (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [umh_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem status pins, active low
  input wire logic send_clearance_in_n,
  input wire logic set_ready_in_n,
  input wire logic carrier_detect_in_n,
  input wire logic ring_detect_in_n,
  // Modem control pins, active low
  output logic terminal_ready_out_n,
  output logic send_request_out_n,
  // Interrupt
  output logic modem_irq
);
  import umh_pkg::*;

  logic [NUM_INPUTS-1:0] pins_n;
  logic [NUM_INPUTS-1:0] level_n;
  logic [NUM_INPUTS-1:0] change;
  logic [NUM_INPUTS-1:0] rise;
  logic [NUM_INPUTS-1:0] delta;
  logic [NUM_INPUTS-1:0] next_delta;
  logic [NUM_INPUTS-1:0] delta_clear;
  logic [7:0] modem_control_reg;
  logic [7:0] modem_status_reg;
  logic [7:0] irq_enable_reg;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic [31:0] next_prdata;
  logic setup;
  logic access;
  logic mapped;
  logic wr_control;
  logic wr_enable;
  logic wr_clear;
  logic status_read;
  logic loopback;

  // Index order puts each pin's change flag at its own status bit
  assign pins_n = {carrier_detect_in_n, ring_detect_in_n, set_ready_in_n,
                   send_clearance_in_n};

  umh_pin_sync #(
    .WIDTH(NUM_INPUTS)
  ) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .pins_n(pins_n),
    .level_n(level_n),
    .change(change)
  );

  // A change from a low level is a rise of the pin
  assign rise = change & ~level_n;

  // APB decode; every access completes without wait states
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    mapped = 1'b0;
    unique case (paddr)
      ADDR_MODEM_CONTROL, ADDR_MODEM_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_STATUS,
      ADDR_IRQ_CLEAR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign pslverr = access && !mapped;
  assign wr_control = access && pwrite && (paddr == ADDR_MODEM_CONTROL);
  assign wr_enable = access && pwrite && (paddr == ADDR_IRQ_ENABLE);
  assign wr_clear = access && pwrite && (paddr == ADDR_IRQ_CLEAR);
  assign status_read = access && !pwrite && (paddr == ADDR_MODEM_STATUS);

  // Modem control register and pins
  assign loopback = modem_control_reg[CTRL_LOOPBACK_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      modem_control_reg <= CTRL_RESET;
    end else if (wr_control) begin
      modem_control_reg <= pwdata[7:0] & CTRL_WRITE_MASK;
    end
  end

  // Pins load with the register so loopback never lets a pulse through
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      terminal_ready_out_n <= 1'b1;
      send_request_out_n <= 1'b1;
    end else if (wr_control) begin
      terminal_ready_out_n <= !(pwdata[CTRL_TERMINAL_READY_BIT] &&
                                !pwdata[CTRL_LOOPBACK_BIT]);
      send_request_out_n <= !(pwdata[CTRL_SEND_REQUEST_BIT] &&
                              !pwdata[CTRL_LOOPBACK_BIT]);
    end
  end

  // Status levels are live; the clearance pin also feeds delta[0] and the modem interrupt
  assign modem_status_reg = {~level_n, delta};

  // Only flags already returned in the read data are cleared, so a rise
  // between setup and access is kept for the next read
  assign delta_clear = status_read ? prdata[NUM_INPUTS-1:0] : DELTA_RESET;
  assign next_delta = (delta & ~delta_clear) | rise;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      delta <= DELTA_RESET;
    end else begin
      delta <= next_delta;
    end
  end

  // Interrupt enable and sticky status
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_enable_reg <= IRQ_ENABLE_RESET;
    end else if (wr_enable) begin
      irq_enable_reg <= pwdata[7:0];
    end
  end

  assign irq_set = (|change) ? IRQ_MODEM_MASK : IRQ_STATUS_RESET;
  assign irq_clear = (wr_clear ? pwdata[IRQ_WIDTH-1:0] : IRQ_STATUS_RESET) |
                     (status_read ? IRQ_MODEM_MASK : IRQ_STATUS_RESET);

  umh_irq_sticky #(
    .WIDTH(IRQ_WIDTH)
  ) u_irq (
    .clock(clock),
    .reset(reset),
    .set(irq_set),
    .clear(irq_clear),
    .enable(irq_enable_reg),
    .status(irq_status),
    .irq(modem_irq)
  );

  // Read data is captured in the setup cycle and held through access
  always_comb begin
    next_prdata = READ_ZERO;
    unique case (paddr)
      ADDR_MODEM_CONTROL: begin
        next_prdata[7:0] = modem_control_reg;
      end
      ADDR_MODEM_STATUS: begin
        next_prdata[7:0] = modem_status_reg;
      end
      ADDR_IRQ_ENABLE: begin
        next_prdata[7:0] = irq_enable_reg;
      end
      ADDR_IRQ_STATUS: begin
        next_prdata[IRQ_WIDTH-1:0] = irq_status;
      end
      default: begin
        next_prdata = READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= READ_ZERO;
    end else if (setup) begin
      prdata <= pwrite ? READ_ZERO : next_prdata;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  chk_ready_write: assert property (wr_control |=> terminal_ready_out_n ==
    !($past(pwdata[CTRL_TERMINAL_READY_BIT]) && !$past(pwdata[CTRL_LOOPBACK_BIT])))
    else $error("Terminal-ready pin does not follow control bit");

  chk_reset_idle: assert property ($fell(reset) |-> terminal_ready_out_n)
    else $error("Terminal-ready pin not idle after reset");

  chk_send_reset: assert property ($fell(reset) |-> send_request_out_n)
    else $error("Send-request pin not idle after reset");

  chk_loop_hold: assert property (loopback |-> terminal_ready_out_n &&
    send_request_out_n)
    else $error("Control pin active during loopback");

  chk_loop_write: assert property (wr_control && pwdata[CTRL_LOOPBACK_BIT] |=>
    terminal_ready_out_n && send_request_out_n)
    else $error("Loopback write let a control pin through");

  chk_pins_hold: assert property (!wr_control |=>
    $stable(terminal_ready_out_n) && $stable(send_request_out_n))
    else $error("Control pin moved without a control write");

  chk_send_write: assert property (wr_control && !pwdata[CTRL_LOOPBACK_BIT] |=>
    send_request_out_n == !$past(pwdata[CTRL_SEND_REQUEST_BIT]))
    else $error("Send-request pin does not follow control bit");

  chk_clear_level: assert property (setup && !pwrite && paddr == ADDR_MODEM_STATUS
    |=> prdata[STATUS_LEVEL_LSB] == !$past(level_n[0]))
    else $error("Clearance level bit wrong");

  chk_ready_level: assert property (setup && !pwrite && paddr == ADDR_MODEM_STATUS
    |=> prdata[STATUS_LEVEL_LSB+1] == !$past(level_n[1]))
    else $error("Set-ready level bit wrong");

  chk_ring_level: assert property (setup && !pwrite && paddr == ADDR_MODEM_STATUS
    |=> prdata[STATUS_LEVEL_LSB+2] == !$past(level_n[2]))
    else $error("Ring level bit wrong");

  chk_carrier_level: assert property (setup && !pwrite && paddr == ADDR_MODEM_STATUS
    |=> prdata[STATUS_LEVEL_LSB+3] == !$past(level_n[3]))
    else $error("Carrier level bit wrong");

  chk_clear_delta: assert property (rise[0] |=> delta[0])
    else $error("Clearance rise not flagged");

  chk_ready_delta: assert property (rise[1] |=> delta[1])
    else $error("Set-ready rise not flagged");

  chk_ring_delta: assert property (rise[2] |=> delta[2])
    else $error("Ring rise not flagged");

  chk_carrier_delta: assert property (rise[3] |=> delta[3])
    else $error("Carrier rise not flagged");

  chk_fall_quiet: assert property (change[0] && level_n[0] && !delta[0] &&
    !status_read |=> !delta[0])
    else $error("Clearance fall wrongly flagged");

  chk_flags_quiet: assert property (rise == DELTA_RESET |=>
    (delta & ~$past(delta)) == DELTA_RESET)
    else $error("Change flag set without a rising pin");

  chk_read_clears: assert property (status_read && rise == DELTA_RESET |=>
    (delta & $past(prdata[NUM_INPUTS-1:0])) == DELTA_RESET)
    else $error("Status read left change flags set");

  chk_irq_raise: assert property ((|change) && irq_enable_reg[IRQ_MODEM_BIT] &&
    !wr_enable |=> modem_irq)
    else $error("Modem interrupt not raised on pin change");

  chk_irq_follows: assert property (irq_status[IRQ_MODEM_BIT] &&
    irq_enable_reg[IRQ_MODEM_BIT] |-> modem_irq)
    else $error("Enabled modem event not signalled");

  chk_irq_masked: assert property (!irq_enable_reg[IRQ_MODEM_BIT] |-> !modem_irq)
    else $error("Masked modem event raised the interrupt");

  chk_irq_quiet: assert property (!(|change) |=>
    !irq_status[IRQ_MODEM_BIT] || $past(irq_status[IRQ_MODEM_BIT]))
    else $error("Modem event latched without a pin change");

  chk_irq_withdraw: assert property (status_read && !(|change) && !wr_enable
    |=> !modem_irq [*1] ##1 1)
    else $error("Status read did not withdraw interrupt");

endmodule // umh_modem_handshake

`default_nettype wire

// >>> umh_modem_model.sv
/*
  Behavioural modem on the line side: drives the four status pins.
  Assumes the bench asks for asserted lines through assert_req.
*/
`timescale 1ns/1ps
`default_nettype none

module umh_modem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bench request: 0 clearance, 1 set-ready, 2 ring, 3 carrier
  input wire logic [3:0] assert_req,
  // Status pins, active low
  output logic send_clearance_in_n,
  output logic set_ready_in_n,
  output logic ring_detect_in_n,
  output logic carrier_detect_in_n
);
  // Low means asserted, high otherwise; idle high after reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {carrier_detect_in_n, ring_detect_in_n, set_ready_in_n, send_clearance_in_n} <= 4'hF;
    end else begin
      {carrier_detect_in_n, ring_detect_in_n, set_ready_in_n, send_clearance_in_n} <= ~assert_req;
    end
  end
endmodule // umh_modem_model

`default_nettype wire

// >>> umh_pin_sync.sv
/*
  Three-stage synchroniser and glitch filter for the active-low modem inputs.
  Assumes the pins are asynchronous to clock and idle high.
*/
`timescale 1ns/1ps
`default_nettype none

module umh_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Raw pins
  input wire logic [WIDTH-1:0] pins_n,
  // Filtered levels and one-cycle change pulses
  output logic [WIDTH-1:0] level_n,
  output logic [WIDTH-1:0] change
);
  import umh_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      logic agree;

      // Stage one feeds stage two only, so metastability stays contained
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          stage1 <= PIN_IDLE;
          stage2 <= PIN_IDLE;
          stage3 <= PIN_IDLE;
        end else begin
          stage1 <= pins_n[i];
          stage2 <= stage1;
          stage3 <= stage2;
        end
      end

      assign agree = (stage2 == stage3);

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          level_n[i] <= PIN_IDLE;
        end else if (agree) begin
          level_n[i] <= stage3;
        end
      end

      assign change[i] = agree && (stage3 != level_n[i]);
    end
  endgenerate

endmodule // umh_pin_sync

`default_nettype wire

// >>> umh_pkg.sv
/*
  Shared constants of the modem handshake block: register offsets, field
  positions, masks and values after reset.
  Assumes an APB slave with 32-bit data and byte addresses in an 8-bit field.
*/
`default_nettype none

package umh_pkg;

  // Register byte offsets
  localparam int unsigned ADDR_WIDTH = 8;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_MODEM_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;

  // Modem control fields
  localparam int unsigned CTRL_TERMINAL_READY_BIT = 0;
  localparam int unsigned CTRL_SEND_REQUEST_BIT = 1;
  localparam int unsigned CTRL_LOOPBACK_BIT = 4;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h13;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Modem status fields: change flags low, complemented levels high
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned STATUS_DELTA_LSB = 0;
  localparam int unsigned STATUS_LEVEL_LSB = 4;
  localparam logic [3:0] DELTA_RESET = 4'h0;

  // Interrupt fields, same layout in enable, status and clear
  localparam int unsigned IRQ_WIDTH = 8;
  localparam int unsigned IRQ_MODEM_BIT = 3;
  localparam logic [7:0] IRQ_MODEM_MASK = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;

  // Pin levels
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire
